// *** verilog/drll_params.svh ***
// Purpose: Constants for the DDR read latency lookup link
// Assumes: Included wherever these constants are used
// Notes: Lookup content is the device's fixed query table
`ifndef DRLL_PARAMS_SVH
`define DRLL_PARAMS_SVH
`define DRLL_CMD_FAST3 8'h0D
`define DRLL_CMD_FAST4 8'h0E
`define DRLL_CMD_DUAL3 8'hBD
`define DRLL_CMD_DUAL4 8'hBE
`define DRLL_CMD_QUAD3 8'hED
`define DRLL_CMD_QUAD4 8'hEE
`define DRLL_LC00 2'h0
`define DRLL_LC01 2'h1
`define DRLL_LC10 2'h2
`define DRLL_LC11 2'h3
`define DRLL_Q10_LAT 8'h08
`define DRLL_TBL_LEN 44
`define DRLL_TBL_INIT '{ \
    8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43, `DRLL_CMD_FAST3, `DRLL_CMD_FAST4, \
    `DRLL_CMD_DUAL3, `DRLL_CMD_DUAL4, `DRLL_CMD_QUAD3, `DRLL_CMD_QUAD4, \
    8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h03, \
    8'h42, 8'h00, 8'h00, 8'h05, 8'h00, 8'h06, 8'h01, 8'h06, \
    8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h07, 8'h01, 8'h07, \
    8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, `DRLL_Q10_LAT}
`define DRLL_ROW_C11 6'h0C
`define DRLL_ROW_C00 6'h14
`define DRLL_ROW_C01 6'h1C
`define DRLL_ROW_C10 6'h24
`define DRLL_OFS_FREQ 6'h00
`define DRLL_OFS_MODE_FAST 6'h02
`define DRLL_OFS_LAT_FAST 6'h03
`define DRLL_OFS_MODE_DUAL 6'h04
`define DRLL_OFS_LAT_DUAL 6'h05
`define DRLL_OFS_MODE_QUAD 6'h06
`define DRLL_OFS_LAT_QUAD 6'h07
`define DRLL_BLANK 8'hFF
`define DRLL_LW1 2'h0
`define DRLL_LW2 2'h1
`define DRLL_LW4 2'h2
`define DRLL_OE_SI 4'h1
`define DRLL_OE_SO 4'h2
`define DRLL_OE_DUAL 4'h3
`define DRLL_OE_QUAD 4'hF
`define DRLL_ADDR3_BITS 7'h18
`define DRLL_ADDR4_BITS 7'h20
`define DRLL_BYTE_BITS 7'h08
`define DRLL_CMD_LAST_EDGE 7'h0E
`define DRLL_ADDR_FIRST_EDGE 7'h0F
`define DRLL_PINS_IDLE 6'h2F
`define DRLL_CORE_MHZ 8'h32
`define DRLL_SCK_DIV_LOG 5
`define DRLL_HALF_DRIVE 4'h8
`define DRLL_HALF_LAST 4'hF
`endif

// *** verilog/drll_pkg.sv ***
// Purpose: Types and helpers shared by both link ends
// Assumes: drll_params.svh on the include path
// Notes: Lane helpers keep data msb first
`default_nettype none
package drll_pkg;
`include "drll_params.svh"

typedef enum logic [1:0] {
    DRLL_K_FAST = 2'b00,
    DRLL_K_DUAL = 2'b01,
    DRLL_K_QUAD = 2'b10,
    DRLL_K_NONE = 2'b11
} drll_kind_t;

typedef enum logic [1:0] {
    DRLL_H_IDLE = 2'b00,
    DRLL_H_RUN = 2'b01,
    DRLL_H_END = 2'b10
} drll_hstate_t;

typedef struct packed {
    logic ok;
    drll_kind_t kind;
    logic addr4;
    logic [1:0] lw;
} drll_cmd_t;

typedef logic [7:0] drll_byte_t;

function automatic drll_cmd_t drll_decode(input logic [7:0] op);
    drll_cmd_t c;
    c = '{ok: 1'h1, kind: DRLL_K_FAST, addr4: 1'h0, lw: `DRLL_LW1};
    case (op)
        `DRLL_CMD_FAST3: c.kind = DRLL_K_FAST;
        `DRLL_CMD_FAST4: c.addr4 = 1'h1;
        `DRLL_CMD_DUAL3: c = '{ok: 1'h1, kind: DRLL_K_DUAL, addr4: 1'h0, lw: `DRLL_LW2};
        `DRLL_CMD_DUAL4: c = '{ok: 1'h1, kind: DRLL_K_DUAL, addr4: 1'h1, lw: `DRLL_LW2};
        `DRLL_CMD_QUAD3: c = '{ok: 1'h1, kind: DRLL_K_QUAD, addr4: 1'h0, lw: `DRLL_LW4};
        `DRLL_CMD_QUAD4: c = '{ok: 1'h1, kind: DRLL_K_QUAD, addr4: 1'h1, lw: `DRLL_LW4};
        default: c = '{ok: 1'h0, kind: DRLL_K_NONE, addr4: 1'h0, lw: `DRLL_LW1};
    endcase
    return c;
endfunction

function automatic logic [5:0] drll_row(input logic [1:0] code);
    case (code)
        `DRLL_LC00: return `DRLL_ROW_C00;
        `DRLL_LC01: return `DRLL_ROW_C01;
        `DRLL_LC10: return `DRLL_ROW_C10;
        default: return `DRLL_ROW_C11;
    endcase
endfunction

function automatic logic [5:0] drll_mode_ofs(input drll_kind_t k);
    case (k)
        DRLL_K_DUAL: return `DRLL_OFS_MODE_DUAL;
        DRLL_K_QUAD: return `DRLL_OFS_MODE_QUAD;
        default: return `DRLL_OFS_MODE_FAST;
    endcase
endfunction

function automatic logic [5:0] drll_lat_ofs(input drll_kind_t k);
    case (k)
        DRLL_K_DUAL: return `DRLL_OFS_LAT_DUAL;
        DRLL_K_QUAD: return `DRLL_OFS_LAT_QUAD;
        default: return `DRLL_OFS_LAT_FAST;
    endcase
endfunction

function automatic logic [3:0] drll_oe(input logic [1:0] lw, input logic isOut);
    case (lw)
        `DRLL_LW2: return `DRLL_OE_DUAL;
        `DRLL_LW4: return `DRLL_OE_QUAD;
        default: return isOut ? `DRLL_OE_SO : `DRLL_OE_SI;
    endcase
endfunction

// Top bits of b onto the lanes; single lane uses io1 out, io0 in
function automatic logic [3:0] drll_place(input logic [1:0] lw, input logic [7:0] b, input logic isOut);
    case (lw)
        `DRLL_LW2: return {2'h0, b[7:6]};
        `DRLL_LW4: return b[7:4];
        default: return isOut ? {2'h0, b[7], 1'h0} : {3'h0, b[7]};
    endcase
endfunction

function automatic logic [3:0] drll_pick(input logic [1:0] lw, input logic [3:0] ln, input logic isOut);
    case (lw)
        `DRLL_LW2: return {2'h0, ln[1:0]};
        `DRLL_LW4: return ln;
        default: return {3'h0, isOut ? ln[1] : ln[0]};
    endcase
endfunction

function automatic logic [31:0] drll_shin(input logic [1:0] lw, input logic [31:0] v, input logic [3:0] b);
    case (lw)
        `DRLL_LW2: return {v[29:0], b[1:0]};
        `DRLL_LW4: return {v[27:0], b};
        default: return {v[30:0], b[0]};
    endcase
endfunction

function automatic logic [6:0] drll_edges(input logic [1:0] lw, input logic [6:0] bits);
    return bits >> lw;
endfunction

endpackage
`default_nettype wire

// *** verilog/drll_link_if.sv ***
// Purpose: Serial link between host end and flash end
// Assumes: Both ends clocked by their own core clocks
// Notes: Undriven io lines read high
`default_nettype none
interface drll_link_if;
    logic chipSel_b;
    logic sck;
    logic [3:0] hostIoOut;
    logic [3:0] hostIoOe;
    logic [3:0] devIoOut;
    logic [3:0] devIoOe;
    logic [3:0] ioLevel;

    assign ioLevel = (hostIoOe & hostIoOut) | (devIoOe & devIoOut) | ~(hostIoOe | devIoOe);

    modport host (
        output chipSel_b,
        output sck,
        output hostIoOut,
        output hostIoOe,
        input ioLevel
    );

    modport dev (
        input chipSel_b,
        input sck,
        input ioLevel,
        output devIoOut,
        output devIoOe
    );
endinterface
`default_nettype wire

// *** verilog/drll_flash_end.sv ***
// Purpose: Flash end of the DDR read path with latency lookup
// Assumes: Host keeps its link clock within the looked-up limit
// Notes: Reads return fixed lookup bytes indexed by low address bits
// Notes on behaviour
// - Fast DDR read uses no mode cycles
// - DDR dual read uses no mode cycles
// - DDR quad read takes one mode cycle
// - Code 11: dummies four, four, three
// - Code 00: dummies five, six, six
// - Code 01: dummies six, seven, seven
// - Code 10: dummies seven, eight for fast/dual
// - Codes 00-10 limit clock to 66 MHz
// - Code 11 limits clock to 50 MHz
// - Opcodes 0D/0E, BD/BE, ED/EE, 3/4-byte address
`default_nettype none
`include "drll_params.svh"
module drll_flash_end
    import drll_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    drll_link_if.dev link,
    input wire logic [1:0] latCode,
    output logic [7:0] freqLimit_q,
    output logic [7:0] modeBits_q,
    output logic dataActive_q
);

    // Fixed lookup content
    localparam drll_byte_t LUT [0:`DRLL_TBL_LEN-1] = `DRLL_TBL_INIT;

    logic [5:0] syncA_q;
    logic [5:0] syncB_q;
    logic [5:0] syncC_q;
    logic [5:0] pins_q;
    logic [5:0] pins_d;
    logic [5:0] prev_q;
    logic [6:0] eCnt_q;
    logic [7:0] cmdSh_q;
    drll_cmd_t cmd_q;
    logic [1:0] code_q;
    logic [31:0] addrSh_q;
    logic [7:0] outSh_q;
    logic [6:0] left_q;
    logic [5:0] ptr_q;
    logic [3:0] ioOut_q;
    logic [3:0] ioOe_q;

    logic selected;
    logic anyEdge;
    logic riseEdge;
    logic [3:0] lanes;
    logic [5:0] row;
    logic [6:0] addrEnd;
    logic [6:0] modeEnd;
    logic [6:0] dumEnd;
    logic [6:0] units;
    logic linkEdge;
    logic inAddr;
    logic inMode;
    logic firstData;
    logic dataEdge;
    logic [5:0] rdIdx;
    drll_byte_t rdByte;

    // Pin synchroniser, value accepted once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q <= `DRLL_PINS_IDLE;
            syncB_q <= `DRLL_PINS_IDLE;
            syncC_q <= `DRLL_PINS_IDLE;
            pins_q <= `DRLL_PINS_IDLE;
            prev_q <= `DRLL_PINS_IDLE;
        end else begin
            syncA_q <= {link.chipSel_b, link.sck, link.ioLevel};
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
            pins_q <= pins_d;
            prev_q <= pins_q;
        end
    end

    assign pins_d = (~(syncB_q ^ syncC_q) & syncC_q) | ((syncB_q ^ syncC_q) & pins_q);
    assign selected = ~pins_q[5];
    assign anyEdge = selected & (pins_q[4] ^ prev_q[4]);
    assign riseEdge = anyEdge & pins_q[4];
    assign lanes = pins_q[3:0];

    // Phase bounds in link edges from the lookup
    always_comb begin
        row = drll_row(code_q);
        addrEnd = 7'(`DRLL_ADDR_FIRST_EDGE +
                      drll_edges(cmd_q.lw, cmd_q.addr4 ? `DRLL_ADDR4_BITS : `DRLL_ADDR3_BITS));
        modeEnd = 7'(addrEnd + {LUT[row + drll_mode_ofs(cmd_q.kind)][5:0], 1'h0});
        dumEnd = 7'(modeEnd + {LUT[row + drll_lat_ofs(cmd_q.kind)][5:0], 1'h0});
        units = drll_edges(cmd_q.lw, `DRLL_BYTE_BITS);
    end

    assign linkEdge = anyEdge & cmd_q.ok;
    assign inAddr = linkEdge & (eCnt_q >= `DRLL_ADDR_FIRST_EDGE) & (eCnt_q < addrEnd);
    assign inMode = linkEdge & (eCnt_q >= addrEnd) & (eCnt_q < modeEnd);
    assign firstData = linkEdge & (eCnt_q == 7'(dumEnd - 7'h01));
    assign dataEdge = linkEdge & (eCnt_q >= 7'(dumEnd - 7'h01));
    assign rdIdx = firstData ? addrSh_q[5:0] : ptr_q;
    assign rdByte = (rdIdx < 6'(`DRLL_TBL_LEN)) ? LUT[rdIdx] : `DRLL_BLANK;

    // Edge counter, restarts whenever the chip is deselected
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            eCnt_q <= 7'h00;
        end else if (!selected) begin
            eCnt_q <= 7'h00;
        end else if (anyEdge) begin
            eCnt_q <= 7'(eCnt_q + 7'h01);
        end
    end

    // Opcode capture on rising edges, decode on the eighth
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdSh_q <= 8'h00;
            cmd_q <= '{ok: 1'h0, kind: DRLL_K_NONE, addr4: 1'h0, lw: `DRLL_LW1};
            code_q <= `DRLL_LC11;
        end else if (!selected) begin
            cmd_q.ok <= 1'h0;
        end else if (riseEdge && eCnt_q <= `DRLL_CMD_LAST_EDGE) begin
            cmdSh_q <= {cmdSh_q[6:0], lanes[0]};
            if (eCnt_q == `DRLL_CMD_LAST_EDGE) begin
                cmd_q <= drll_decode({cmdSh_q[6:0], lanes[0]});
                code_q <= latCode;
            end
        end
    end

    // Address on both edges, width set by the opcode
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addrSh_q <= 32'h0000_0000;
        end else if (inAddr) begin
            addrSh_q <= drll_shin(cmd_q.lw, addrSh_q, drll_pick(cmd_q.lw, lanes, 1'h0));
        end
    end

    // Mode bits sampled ahead of the dummy period
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            modeBits_q <= 8'h00;
        end else if (inMode) begin
            modeBits_q <= 8'(drll_shin(cmd_q.lw, {24'h00_0000, modeBits_q}, lanes));
        end
    end

    // Read data shifter, one lane group per link edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            outSh_q <= 8'h00;
            left_q <= 7'h00;
            ptr_q <= 6'h00;
            ioOut_q <= 4'h0;
        end else if (!selected) begin
            left_q <= 7'h00;
        end else if (dataEdge) begin
            if (firstData || left_q == 7'h00) begin
                ioOut_q <= drll_place(cmd_q.lw, rdByte, 1'h1);
                outSh_q <= 8'(drll_shin(cmd_q.lw, {24'h00_0000, rdByte}, 4'h0));
                left_q <= 7'(units - 7'h01);
                ptr_q <= 6'(rdIdx + 6'h01);
            end else begin
                ioOut_q <= drll_place(cmd_q.lw, outSh_q, 1'h1);
                outSh_q <= 8'(drll_shin(cmd_q.lw, {24'h00_0000, outSh_q}, 4'h0));
                left_q <= 7'(left_q - 7'h01);
            end
        end
    end

    // Output enables stay low through the dummy period
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ioOe_q <= 4'h0;
            dataActive_q <= 1'h0;
        end else if (!selected) begin
            ioOe_q <= 4'h0;
            dataActive_q <= 1'h0;
        end else if (firstData) begin
            ioOe_q <= drll_oe(cmd_q.lw, 1'h1);
            dataActive_q <= 1'h1;
        end
    end

    // Clock limit for the configured code, 66 MHz or 50 MHz
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            freqLimit_q <= 8'h00;
        end else begin
            freqLimit_q <= LUT[drll_row(latCode) + `DRLL_OFS_FREQ];
        end
    end

    assign link.devIoOut = ioOut_q;
    assign link.devIoOe = ioOe_q;

endmodule
`default_nettype wire

// *** verilog/drll_host_end.sv ***
// Purpose: Host end issuing one-byte DDR reads
// Assumes: Flash end uses the same lookup content
// Notes: Link clock is core clock divided by thirty-two
`default_nettype none
`include "drll_params.svh"
module drll_host_end
    import drll_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    drll_link_if.host link,
    input wire logic startReq,
    input wire logic [7:0] opCode,
    input wire logic [31:0] address,
    input wire logic [1:0] latCode,
    output logic [7:0] readData_q,
    output logic readValid_q,
    output logic busy_q,
    output logic rejected_q
);

    localparam drll_byte_t LUT [0:`DRLL_TBL_LEN-1] = `DRLL_TBL_INIT;
    localparam logic [7:0] SCK_MHZ = 8'(`DRLL_CORE_MHZ >> `DRLL_SCK_DIV_LOG);

    drll_hstate_t state_q;
    logic [4:0] ph_q;
    logic sck_q;
    logic chipSel_b_q;
    logic [6:0] eCnt_q;
    drll_cmd_t cmd_q;
    logic [1:0] code_q;
    logic [7:0] cmdSh_q;
    logic [31:0] addrSh_q;
    logic [7:0] rx_q;
    logic [3:0] ioOut_q;
    logic [3:0] ioOe_q;
    logic [3:0] syncA_q;
    logic [3:0] syncB_q;
    logic [3:0] syncC_q;
    logic [3:0] in_q;

    drll_cmd_t reqCmd;
    logic [5:0] row;
    logic [6:0] addrEnd;
    logic [6:0] modeEnd;
    logic [6:0] dumEnd;
    logic [6:0] lastEdge;
    logic driveSlot;
    logic edgeSlot;
    logic launch;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q <= 4'hF;
            syncB_q <= 4'hF;
            syncC_q <= 4'hF;
            in_q <= 4'hF;
        end else begin
            syncA_q <= link.ioLevel;
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
            in_q <= (~(syncB_q ^ syncC_q) & syncC_q) | ((syncB_q ^ syncC_q) & in_q);
        end
    end

    always_comb begin
        reqCmd = drll_decode(opCode);
        row = drll_row(code_q);
        addrEnd = 7'(`DRLL_ADDR_FIRST_EDGE +
                      drll_edges(cmd_q.lw, cmd_q.addr4 ? `DRLL_ADDR4_BITS : `DRLL_ADDR3_BITS));
        modeEnd = 7'(addrEnd + {LUT[row + drll_mode_ofs(cmd_q.kind)][5:0], 1'h0});
        dumEnd = 7'(modeEnd + {LUT[row + drll_lat_ofs(cmd_q.kind)][5:0], 1'h0});
        lastEdge = 7'(dumEnd + drll_edges(cmd_q.lw, `DRLL_BYTE_BITS));
    end

    assign driveSlot = (state_q == DRLL_H_RUN) && (ph_q[3:0] == `DRLL_HALF_DRIVE);
    assign edgeSlot = (state_q == DRLL_H_RUN) && (ph_q[3:0] == `DRLL_HALF_LAST);
    // Refuse unknown opcodes and a link clock above the row limit
    assign launch = (state_q == DRLL_H_IDLE) && startReq && reqCmd.ok &&
                    (SCK_MHZ <= LUT[drll_row(latCode) + `DRLL_OFS_FREQ]);

    // Sequencing and link clock
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= DRLL_H_IDLE;
            ph_q <= 5'h00;
            sck_q <= 1'h0;
            chipSel_b_q <= 1'h1;
            eCnt_q <= 7'h00;
            busy_q <= 1'h0;
            readValid_q <= 1'h0;
            rejected_q <= 1'h0;
            readData_q <= 8'h00;
        end else begin
            readValid_q <= 1'h0;
            rejected_q <= 1'h0;
            case (state_q)
                DRLL_H_IDLE: begin
                    if (launch) begin
                        state_q <= DRLL_H_RUN;
                        ph_q <= 5'h00;
                        eCnt_q <= 7'h00;
                        chipSel_b_q <= 1'h0;
                        busy_q <= 1'h1;
                    end else if (startReq) begin
                        rejected_q <= 1'h1;
                    end
                end
                DRLL_H_RUN: begin
                    ph_q <= 5'(ph_q + 5'h01);
                    if (edgeSlot) begin
                        sck_q <= ~sck_q;
                        eCnt_q <= 7'(eCnt_q + 7'h01);
                        if (eCnt_q == lastEdge) begin
                            // Deselect with the closing edge, keeps the idle gap wide
                            state_q <= DRLL_H_END;
                            chipSel_b_q <= 1'h1;
                        end
                    end
                end
                DRLL_H_END: begin
                    ph_q <= 5'(ph_q + 5'h01);
                    if (ph_q[3:0] == `DRLL_HALF_DRIVE) begin
                        busy_q <= 1'h0;
                        readValid_q <= 1'h1;
                        readData_q <= rx_q;
                        state_q <= DRLL_H_IDLE;
                    end
                end
                default: state_q <= DRLL_H_IDLE;
            endcase
        end
    end

    // Pin drive, half a phase ahead of each link edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= '{ok: 1'h0, kind: DRLL_K_NONE, addr4: 1'h0, lw: `DRLL_LW1};
            code_q <= `DRLL_LC11;
            cmdSh_q <= 8'h00;
            addrSh_q <= 32'h0000_0000;
            ioOut_q <= 4'h0;
            ioOe_q <= 4'h0;
        end else if (launch) begin
            cmd_q <= reqCmd;
            code_q <= latCode;
            cmdSh_q <= opCode;
            addrSh_q <= reqCmd.addr4 ? address : {address[23:0], 8'h00};
            ioOut_q <= 4'h0;
            ioOe_q <= `DRLL_OE_SI;
        end else if (state_q == DRLL_H_END && ph_q[3:0] == `DRLL_HALF_DRIVE) begin
            ioOe_q <= 4'h0;
        end else if (driveSlot) begin
            if (eCnt_q <= `DRLL_CMD_LAST_EDGE) begin
                if (!eCnt_q[0]) begin
                    ioOut_q <= {3'h0, cmdSh_q[7]};
                    cmdSh_q <= {cmdSh_q[6:0], 1'h0};
                end
            end else if (eCnt_q < addrEnd) begin
                ioOut_q <= drll_place(cmd_q.lw, addrSh_q[31:24], 1'h0);
                addrSh_q <= drll_shin(cmd_q.lw, addrSh_q, 4'h0);
                ioOe_q <= drll_oe(cmd_q.lw, 1'h0);
            end else if (eCnt_q < modeEnd) begin
                ioOut_q <= 4'h0;
                ioOe_q <= drll_oe(cmd_q.lw, 1'h0);
            end else begin
                ioOe_q <= 4'h0;
            end
        end
    end

    // Read data sampled just before each data edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_q <= 8'h00;
        end else if (edgeSlot && eCnt_q >= dumEnd && eCnt_q < lastEdge) begin
            rx_q <= 8'(drll_shin(cmd_q.lw, {24'h00_0000, rx_q}, drll_pick(cmd_q.lw, in_q, 1'h1)));
        end
    end

    assign link.chipSel_b = chipSel_b_q;
    assign link.sck = sck_q;
    assign link.hostIoOut = ioOut_q;
    assign link.hostIoOe = ioOe_q;

endmodule
`default_nettype wire

// *** bench/drll_link_sva.sv ***
// Purpose: Link checks between host end and flash end
// Assumes: Both ends run on the bench core clock
// Notes: Sees only the interface signals
`default_nettype none
module drll_link_sva (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic chipSel_b,
    input wire logic sck,
    input wire logic [3:0] hostIoOut,
    input wire logic [3:0] hostIoOe,
    input wire logic [3:0] devIoOut,
    input wire logic [3:0] devIoOe,
    input wire logic [3:0] ioLevel
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_noFight; (hostIoOe & devIoOe) == 4'h0; endproperty
    a_noFight: assert property (p_noFight) else $error("Both ends drive one lane");
    property p_devQuietIdle; chipSel_b [*8] |-> devIoOe == 4'h0; endproperty
    a_devQuietIdle: assert property (p_devQuietIdle) else $error("Flash drives while idle");
    property p_sckIdleLow; chipSel_b |-> !sck; endproperty
    a_sckIdleLow: assert property (p_sckIdleLow) else $error("Link clock not low when idle");
    property p_devLanes; devIoOe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
    a_devLanes: assert property (p_devLanes) else $error("Flash lane enables malformed");
    property p_sckHigh; $rose(sck) |-> sck [*8]; endproperty
    a_sckHigh: assert property (p_sckHigh) else $error("Link clock high phase short");
    property p_sckLow; $fell(sck) |-> !sck [*8]; endproperty
    a_sckLow: assert property (p_sckLow) else $error("Link clock low phase short");
    property p_dummyGap; $rose(|devIoOe) |-> $past(hostIoOe, 64) == 4'h0; endproperty
    a_dummyGap: assert property (p_dummyGap) else $error("Dummy period too short");
    property p_devAfterRise; $rose(|devIoOe) |-> sck && !chipSel_b; endproperty
    a_devAfterRise: assert property (p_devAfterRise) else $error("Data drive off its edge");
    property p_csGap; $rose(chipSel_b) |-> chipSel_b [*4]; endproperty
    a_csGap: assert property (p_csGap) else $error("Deselect gap too short");
    c_fast: cover property (devIoOe == 4'h2);
    c_dual: cover property (devIoOe == 4'h3);
    c_quad: cover property (devIoOe == 4'hF);
endmodule
`default_nettype wire

// *** bench/test_ddr_read_latency_lookup.sv ***
// Purpose: Self-checking bench joining host end and flash end
// Assumes: Both ends share the bench core clock
// Notes: Expected bytes and timing come from a local dummy table
`default_nettype none
module test_ddr_read_latency_lookup;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic rej;
        logic [7:0] data;
        int lat;
        int t0;
    } drll_note_t;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic startReq = 1'b0;
    logic [7:0] opCode = 8'h00;
    logic [31:0] address = 32'h0000_0000;
    logic [1:0] latCode = 2'h0;
    logic [7:0] readData, freqLimit, modeBits;
    logic readValid, busy, rejected;
    logic dataActive;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    drll_note_t notes[$];
    drll_note_t got;
    int dum[4][3] = '{'{5, 6, 6}, '{6, 7, 7}, '{7, 8, 8}, '{4, 4, 3}};
    logic [5:0] rowBase[4] = '{6'h14, 6'h1C, 6'h24, 6'h0C};
    logic [7:0] ops[6] = '{8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    drll_link_if drll_link_if_inst ();
    drll_host_end drll_host_end_inst (.core_clk(core_clk), .rst_b(rst_b), .link(drll_link_if_inst.host),
        .startReq(startReq), .opCode(opCode), .address(address), .latCode(latCode), .readData_q(readData),
        .readValid_q(readValid), .busy_q(busy), .rejected_q(rejected));
    drll_flash_end drll_flash_end_inst (.core_clk(core_clk), .rst_b(rst_b), .link(drll_link_if_inst.dev),
        .latCode(latCode), .freqLimit_q(freqLimit), .modeBits_q(modeBits), .dataActive_q(dataActive));
    drll_link_sva drll_link_sva_inst (.core_clk(core_clk), .rst_b(rst_b), .chipSel_b(drll_link_if_inst.chipSel_b),
        .sck(drll_link_if_inst.sck), .hostIoOut(drll_link_if_inst.hostIoOut), .hostIoOe(drll_link_if_inst.hostIoOe),
        .devIoOut(drll_link_if_inst.devIoOut), .devIoOe(drll_link_if_inst.devIoOe),
        .ioLevel(drll_link_if_inst.ioLevel));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One read; kind 3 marks an opcode that must be refused
    task automatic read(input logic [7:0] op, input logic [5:0] ofs, input logic [7:0] exp, input int k);
        drll_note_t n;
        int w;
        logic act;
        act = 1'b0;
        n.rej = (k == 3);
        n.data = exp;
        n.lat = 0;
        if (k < 3) begin
            w = 1 << k;
            n.lat = (16 + (op[0] ? 24 : 32) / w + (k == 2 ? 2 : 0) + 2 * dum[latCode][k] + 8 / w) * 16 + 9;
        end
        @(posedge core_clk);
        #1;
        startReq = 1'b1;
        opCode = op;
        address = ($urandom() & 32'hFFFF_FFC0) | {26'h0, ofs};
        @(posedge core_clk);
        #1;
        n.t0 = cyc;
        notes.push_back(n);
        startReq = 1'b0;
        check({31'h0, busy}, {31'h0, k < 3});
        for (int i = 0; i < 2000 && !(readValid || rejected); i++) begin
            @(negedge core_clk);
            act = act | dataActive;
        end
        check({31'h0, act}, {31'h0, k < 3});
    endtask

    always @(negedge core_clk) begin
        if (readValid || rejected) begin
            check(32'(notes.size()), 32'h1);
            if (notes.size() > 0) begin
                got = notes.pop_front();
                check({31'h0, rejected}, {31'h0, got.rej});
                check(32'(cyc - got.t0), 32'(got.lat));
                if (!got.rej) begin
                    check({24'h0, readData}, {24'h0, got.data});
                end
            end
        end
    end

    initial begin
        int f;
        int k;
        logic [7:0] e;
        void'($urandom(32'heeed));
        repeat (3) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        for (int c = 0; c < 4; c++) begin
            @(posedge core_clk);
            #1;
            latCode = 2'(c);
            repeat (3) @(posedge core_clk);
            #1;
            check({24'h0, freqLimit}, c == 3 ? 32'h32 : 32'h42);
            for (int i = 0; i < 6; i++) begin
                k = i / 2;
                f = (c + i) % 3;
                e = f == 0 ? (c == 3 ? 8'h32 : 8'h42) : f == 1 ? 8'(k == 2) : 8'(dum[c][k]);
                read(ops[i], rowBase[c] + 6'(f == 0 ? 0 : f + 1 + 2 * k), e, k);
                if (k == 2) begin
                    check({24'h0, modeBits}, 32'h0);
                end
            end
        end
        read(8'h0D, 6'h30, 8'hFF, 0);
        read(8'h0B, 6'h00, 8'h00, 3);
        repeat (4) @(posedge core_clk);
        complete_run();
    end

    initial begin
        #1_200_000;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule
`default_nettype wire
